/* err_handling_defines.vh */
`ifndef ERR_HANDLING_DEFINES_VH
`define ERR_HANDLING_DEFINES_VH
// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_ERRNUM      8'h08
`define OFS_IRQ_STAT    8'h0c
`define OFS_IRQ_CLR     8'h10
`define OFS_IRQ_EN      8'h14
// ****************************************
// Control fields
// ****************************************
`define CTRL_FAULT_CLR  0
`define CTRL_BRAKE      1
`define CTRL_MOVE_REQ   2
`define CTRL_RESET_VAL  32'h0000_0000
// ****************************************
// Status byte 1 fields
// ****************************************
`define ST1_READY       0
`define ST1_FAULT       1
// ****************************************
// Interrupt events
// ****************************************
`define IRQ_ERR_SET     0
`define IRQ_ERR_CLR     1
`define IRQ_REFUSED     2
// ****************************************
// Error groups
// ****************************************
`define GRP_POS_RECORD  4'h2
// ****************************************
// Timing
// ****************************************
`define VALVE_TMO_NS    5000000
`define CLK_PERIOD_NS   4
`define VALVE_TMO_CYC   (`VALVE_TMO_NS / `CLK_PERIOD_NS)
`define AXI_RESP_OKAY   2'b00
`define AXI_RESP_SLVERR 2'b10
`endif

/* positioner_error_handling.v */
// Contract
// - Error shows number, fault high, ready low
// - Pending error refuses new positioning tasks
// - Errors never touch the brake output
// - Group 2x keeps controller and supply on
// - Group 2x while moving ramps to stop
// - After 2x clear, hold position regulated
// - Other groups disable controller, centre valve
// - After other clear, stay unregulated
// - Comm error keeps supply; valve self-centres
// - Allow 5 ms valve timeout at init
// - Clear only when cause is gone
// - Host fault-clear clears removed-cause error
// - Handheld clear equals host clear
// - Power cycle resets error state
// - Error bit status byte 1, number byte 3
// - Two-digit number, first error only kept
`timescale 1ns/100ps
`default_nettype none
`include "err_handling_defines.vh"
module positioner_error_handling #(
  parameter VALVE_TMO = `VALVE_TMO_CYC
) (
  // Clock and reset
  input  wire        CORE_CLK_I,
  input  wire        RST_B_I,
  // Error sources
  input  wire        ERR_DET_I,
  input  wire [7:0]  ERR_CODE_I,
  input  wire        ERR_CAUSE_I,
  input  wire        HH_CLEAR_I,
  input  wire        MOVING_I,
  input  wire        VALVE_LINK_OK_I,
  // Actuator side
  output wire        CTRL_EN_O,
  output wire        VALVE_CENTRE_O,
  output wire        RAMP_STOP_O,
  output wire        HOLD_POS_O,
  output wire        LOAD_SUPPLY_O,
  output wire        BRAKE_O,
  output wire        TASK_START_O,
  output wire        VALVE_INIT_DONE_O,
  output wire        VALVE_INIT_FAIL_O,
  // Status bytes
  output wire [7:0]  STATUS1_O,
  output wire [7:0]  STATUS3_O,
  output wire        IRQ_O,
  // AXI4-Lite slave
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  // ****************************************
  // Axis states
  // ****************************************
  localparam [1:0] ST_RUN    = 2'h0;
  localparam [1:0] ST_ERR_RG = 2'h1;
  localparam [1:0] ST_ERR_OFF = 2'h2;
  localparam [1:0] ST_UNREG  = 2'h3;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         pend_q;
  reg  [7:0]  errnum_q;
  reg         ctrl_clr_q;
  reg         clr_prev_q;
  reg         hh_prev_q;
  reg         brake_q;
  reg         move_q;
  reg         task_q;
  reg         ramp_q;
  reg         hold_q;
  reg  [7:0]  status1;
  wire [2:0]  irq_stat;
  reg  [2:0]  irq_en_q;
  reg  [31:0] tmo_q;
  reg         init_done_q;
  reg         init_fail_q;

  // AXI channel state
  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;

  // ****************************************
  // Clear and refuse qualify
  // ****************************************
  // Edges only, so a clear held high cannot wipe a later error
  wire clr_rise = (ctrl_clr_q & ~clr_prev_q) | (HH_CLEAR_I & ~hh_prev_q);
  wire clr_ok   = pend_q & clr_rise & ~ERR_CAUSE_I;
  wire new_err  = ERR_DET_I & ~pend_q;
  wire refuse   = move_q & pend_q;
  wire grp_rec  = (ERR_CODE_I[7:4] == `GRP_POS_RECORD);

  // ****************************************
  // AXI write path
  // ****************************************
  wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  assign S_AXI_AWREADY = ~aw_got_q;
  assign S_AXI_WREADY  = ~w_got_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  reg         wr_ctrl;
  reg         wr_iclr;
  reg         wr_ien;
  reg         wr_map;

  // Only byte lane 0 holds live bits, so other strobes are ignored
  always @* begin
    wr_ctrl = 1'b0;
    wr_iclr = 1'b0;
    wr_ien  = 1'b0;
    wr_map  = 1'b1;
    case (awaddr_q)
      `OFS_CTRL:    wr_ctrl = wr_fire & wstrb_q[0];
      `OFS_IRQ_CLR: wr_iclr = wr_fire & wstrb_q[0];
      `OFS_IRQ_EN:  wr_ien  = wr_fire & wstrb_q[0];
      default:      wr_map  = 1'b0;
    endcase
  end

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= `AXI_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_got_q) begin
        aw_got_q <= 1'b1;
        awaddr_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && !w_got_q) begin
        w_got_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI read path
  // ****************************************
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `AXI_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `AXI_RESP_OKAY;
      case ({S_AXI_ARADDR[7:2], 2'b00})
        `OFS_CTRL:     rdata_q <= {29'h0, move_q, brake_q, ctrl_clr_q};
        `OFS_STATUS:   rdata_q <= {24'h0, STATUS1_O};
        `OFS_ERRNUM:   rdata_q <= {24'h0, STATUS3_O};
        `OFS_IRQ_STAT: rdata_q <= {29'h0, irq_stat};
        `OFS_IRQ_EN:   rdata_q <= {29'h0, irq_en_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `AXI_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_clr_q <= 1'b0;
      brake_q    <= 1'b0;
      move_q     <= 1'b0;
      clr_prev_q <= 1'b0;
      hh_prev_q  <= 1'b0;
    end else begin
      clr_prev_q <= ctrl_clr_q;
      hh_prev_q  <= HH_CLEAR_I;
      if (wr_ctrl) begin
        ctrl_clr_q <= wdata_q[`CTRL_FAULT_CLR];
        brake_q    <= wdata_q[`CTRL_BRAKE];
        move_q     <= wdata_q[`CTRL_MOVE_REQ];
      end
    end
  end

  // ****************************************
  // Error latch and axis reaction
  // ****************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN, ST_UNREG: begin
        if (new_err) begin
          state_d = grp_rec ? ST_ERR_RG : ST_ERR_OFF;
        end
      end
      ST_ERR_RG: begin
        if (clr_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_ERR_OFF: begin
        if (clr_ok) begin
          state_d = ST_UNREG;
        end
      end
      default: state_d = ST_UNREG;
    endcase
  end

  // Reset is the power cycle, so everything restarts clean
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q  <= ST_UNREG;
      pend_q   <= 1'b0;
      errnum_q <= 8'h00;
      task_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (new_err) begin
        pend_q   <= 1'b1;
        errnum_q <= ERR_CODE_I;
      end else if (clr_ok) begin
        pend_q   <= 1'b0;
        errnum_q <= 8'h00;
      end
      task_q <= move_q & ~pend_q & ~new_err & ~brake_q;
    end
  end

  // ****************************************
  // Braking ramp and position hold
  // ****************************************
  // Ramp ends once the axis reports standstill
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ramp_q <= 1'b0;
    end else if (new_err && grp_rec && MOVING_I) begin
      ramp_q <= 1'b1;
    end else if (!MOVING_I || state_q != ST_ERR_RG) begin
      ramp_q <= 1'b0;
    end
  end

  // Hold survives the clear until the host starts a new task
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hold_q <= 1'b0;
    end else if (state_q == ST_ERR_RG) begin
      hold_q <= ~ramp_q;
    end else if (state_q == ST_RUN) begin
      hold_q <= ~task_q;
    end else begin
      hold_q <= 1'b0;
    end
  end

  // ****************************************
  // Valve link timeout
  // ****************************************
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tmo_q       <= 32'h0000_0000;
      init_done_q <= 1'b0;
      init_fail_q <= 1'b0;
    end else if (!init_done_q && !init_fail_q) begin
      if (VALVE_LINK_OK_I) begin
        init_done_q <= 1'b1;
      end else if (tmo_q >= VALVE_TMO - 1) begin
        init_fail_q <= 1'b1;
      end else begin
        tmo_q <= tmo_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire [2:0] irq_ev;
  assign irq_ev[`IRQ_ERR_SET] = new_err;
  assign irq_ev[`IRQ_ERR_CLR] = clr_ok;
  assign irq_ev[`IRQ_REFUSED] = refuse & ~task_q;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
      reg flag_q;
      // Set wins so no event is lost in a clear cycle
      always @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          flag_q <= 1'b0;
        end else if (irq_ev[gi]) begin
          flag_q <= 1'b1;
        end else if (wr_iclr && wdata_q[gi]) begin
          flag_q <= 1'b0;
        end
      end
      assign irq_stat[gi] = flag_q;
    end
  endgenerate

  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      irq_en_q <= 3'h0;
    end else if (wr_ien) begin
      irq_en_q <= wdata_q[2:0];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign IRQ_O          = |(irq_stat & irq_en_q);
  assign CTRL_EN_O      = (state_q == ST_RUN) | (state_q == ST_ERR_RG);
  assign VALVE_CENTRE_O = (state_q == ST_ERR_OFF);
  assign RAMP_STOP_O    = ramp_q;
  assign HOLD_POS_O     = hold_q;
  // Valve self-centres on its own timeout; supply stays on
  assign LOAD_SUPPLY_O  = 1'b1;
  assign BRAKE_O        = brake_q;
  assign TASK_START_O   = task_q;
  assign VALVE_INIT_DONE_O = init_done_q;
  assign VALVE_INIT_FAIL_O = init_fail_q;
  assign STATUS1_O      = status1;
  assign STATUS3_O      = errnum_q;

  // Ready is the plain complement of fault
  always @* begin
    status1             = 8'h00;
    status1[`ST1_READY] = ~pend_q;
    status1[`ST1_FAULT] = pend_q;
  end

endmodule // positioner_error_handling
`default_nettype wire

/* err_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module err_checker (
  // Clock, reset, inputs
  input wire logic       CORE_CLK_I,
  input wire logic       RST_B_I,
  input wire logic       ERR_DET_I,
  input wire logic [7:0] ERR_CODE_I,
  input wire logic       ERR_CAUSE_I,
  input wire logic       MOVING_I,
  // Outputs
  input wire logic       CTRL_EN_O,
  input wire logic       VALVE_CENTRE_O,
  input wire logic       RAMP_STOP_O,
  input wire logic       HOLD_POS_O,
  input wire logic       LOAD_SUPPLY_O,
  input wire logic       BRAKE_O,
  input wire logic       TASK_START_O,
  input wire logic [7:0] STATUS1_O,
  input wire logic [7:0] STATUS3_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire flt = STATUS1_O[1];
  wire g2  = STATUS3_O[7:4] == 4'h2;
  sequence s_new; ERR_DET_I && !flt; endsequence
  sequence s_held; flt ##1 flt; endsequence
  sequence s_quit; $fell(flt); endsequence
  AST_LATCH: assert property (s_new |=> flt && !STATUS1_O[0] && STATUS3_O == $past(ERR_CODE_I))
    else $error("error not latched");
  AST_FIRST: assert property (s_held |-> $stable(STATUS3_O))
    else $error("error number changed");
  AST_REFUSE: assert property (flt |=> !TASK_START_O)
    else $error("task started under error");
  AST_BRAKE: assert property ($rose(flt) |-> $stable(BRAKE_O))
    else $error("brake moved by error");
  AST_REG: assert property (s_held ##0 g2 |-> CTRL_EN_O && LOAD_SUPPLY_O)
    else $error("record error left loop");
  AST_RAMP: assert property ($rose(flt) && g2 && $past(MOVING_I) |-> ##[0:2] RAMP_STOP_O)
    else $error("no braking ramp");
  AST_OFF: assert property (s_held ##0 !g2 |-> !CTRL_EN_O && VALVE_CENTRE_O && LOAD_SUPPLY_O)
    else $error("controller not off");
  AST_CAUSE: assert property (ERR_CAUSE_I [*3] ##0 flt |=> flt)
    else $error("cleared with cause");
  AST_HOLD: assert property (s_quit ##0 $past(g2) |-> ##[0:2] HOLD_POS_O && CTRL_EN_O)
    else $error("no hold after clear");
  AST_UNREG: assert property (s_quit ##0 !$past(g2) |-> !CTRL_EN_O [*4])
    else $error("loop restarted by itself");
endmodule // err_checker
bind positioner_error_handling err_checker u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .ERR_DET_I(ERR_DET_I), .ERR_CODE_I(ERR_CODE_I),
  .ERR_CAUSE_I(ERR_CAUSE_I), .MOVING_I(MOVING_I), .CTRL_EN_O(CTRL_EN_O),
  .VALVE_CENTRE_O(VALVE_CENTRE_O), .RAMP_STOP_O(RAMP_STOP_O), .HOLD_POS_O(HOLD_POS_O),
  .LOAD_SUPPLY_O(LOAD_SUPPLY_O), .BRAKE_O(BRAKE_O), .TASK_START_O(TASK_START_O),
  .STATUS1_O(STATUS1_O), .STATUS3_O(STATUS3_O));
`default_nettype wire

/* plc_host.sv */
`timescale 1ns/100ps
`default_nettype none
module plc_host (
  // Clock
  input  wire logic        clk_i,
  // Write side
  output var  logic [7:0]  aw_o,
  output var  logic        awv_o,
  input  wire logic        awr_i,
  output var  logic [31:0] wd_o,
  output var  logic        wv_o,
  input  wire logic        wr_i,
  input  wire logic [1:0]  br_i,
  input  wire logic        bv_i,
  output var  logic        bq_o,
  // Read side
  output var  logic [7:0]  ar_o,
  output var  logic        arv_o,
  input  wire logic        arr_i,
  input  wire logic [31:0] rd_i,
  input  wire logic [1:0]  rr_i,
  input  wire logic        rv_i,
  output var  logic        rq_o
);
  initial begin
    {aw_o, awv_o, wd_o, wv_o, bq_o, ar_o, arv_o, rq_o} = '0;
  end
  // Fault-clear and commands go through this write
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    {aw_o, wd_o, awv_o, wv_o, bq_o} <= {a, d, 3'b111};
    for (n = 0; n < 64 && !(bq_o && bv_i); n++) begin
      @(posedge clk_i);
      if (awr_i) awv_o <= 1'b0;
      if (wr_i) wv_o <= 1'b0;
    end
    r = br_i;
    bq_o <= 1'b0;
    if (n == 64) begin
      tb_top.bad_count++;
      tb_top.complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    {ar_o, arv_o, rq_o} <= {a, 2'b11};
    for (n = 0; n < 64 && !(rq_o && rv_i); n++) begin
      @(posedge clk_i);
      if (arr_i) arv_o <= 1'b0;
    end
    {d, r} = {rd_i, rr_i};
    rq_o <= 1'b0;
    if (n == 64) begin
      tb_top.bad_count++;
      tb_top.complete_run();
    end
  endtask
endmodule // plc_host
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_b, det, cause, hh, mov, link;
  logic [7:0] code, aw, ar, s1, s3, ec;
  logic [31:0] wd, rd, d;
  logic [1:0] br, rr, r;
  logic en, ctr, rmp, hold, sup, brk, tsk, idn, ifl, irq, awv, awr, wv, wr, bv, bq;
  logic arv, arr, rv, rq;
  int bad_count, n_tests, seed, i;
  logic [3:0] grp [7] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  positioner_error_handling #(.VALVE_TMO(20)) u_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .ERR_DET_I(det), .ERR_CODE_I(code), .ERR_CAUSE_I(cause), .HH_CLEAR_I(hh), .MOVING_I(mov),
    .VALVE_LINK_OK_I(link), .CTRL_EN_O(en), .VALVE_CENTRE_O(ctr), .RAMP_STOP_O(rmp),
    .HOLD_POS_O(hold), .LOAD_SUPPLY_O(sup), .BRAKE_O(brk), .TASK_START_O(tsk),
    .VALVE_INIT_DONE_O(idn), .VALVE_INIT_FAIL_O(ifl), .STATUS1_O(s1), .STATUS3_O(s3), .IRQ_O(irq),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bq), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rq));
  plc_host u_host (.clk_i(clk), .aw_o(aw), .awv_o(awv), .awr_i(awr), .wd_o(wd), .wv_o(wv),
    .wr_i(wr), .br_i(br), .bv_i(bv), .bq_o(bq), .ar_o(ar), .arv_o(arv), .arr_i(arr),
    .rd_i(rd), .rr_i(rr), .rv_i(rv), .rq_o(rq));
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] st1(input logic f);
    return {6'h00, f, ~f};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d, checks %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic ctl(input logic [31:0] v);
    u_host.wr(8'h00, v, r);
    check("bresp", r, 2'b00);
    cyc(3);
  endtask
  // Level detect held two cycles so it spans the latch edge
  task automatic raise(input logic [7:0] c);
    @(posedge clk);
    {det, code} <= {1'b1, c};
    cyc(2);
    det <= 1'b0;
    cyc(3);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    {bad_count, n_tests, seed} = {32'd0, 32'd0, 32'd5308};
    {rst_b, det, cause, hh, mov, link, code} = '0;
    cyc(16);
    rst_b <= 1'b1;
    cyc(10);
    check("init_fail", ifl, 1'b0);
    cyc(30);
    check("init", {ifl, idn}, 2'b10);
    link <= 1'b1;
    check("reset", {s1, s3, sup, en}, {st1(0), 8'h00, 2'b10});
    u_host.rd(8'h40, d, r);
    check("unmapped", r, 2'b10);
    u_host.wr(8'h14, 32'h1, r);
    ctl(32'h4);
    check("task", tsk, 1'b1);
    mov <= 1'b1;
    ec = {4'h2, 4'($unsigned($random(seed)) % 10)};
    raise(ec);
    check("st1", s1, st1(1));
    check("st3", s3, ec);
    check("refuse", tsk, 1'b0);
    check("brake", brk, 1'b0);
    check("regulated", {en, sup, rmp, irq}, 4'hf);
    raise(8'h35);
    check("first", s3, ec);
    u_host.wr(8'h10, 32'h1, r);
    cyc(2);
    check("irq", irq, 1'b0);
    cause <= 1'b1;
    ctl(32'h4);
    ctl(32'h5);
    check("cause", s1, st1(1));
    cause <= 1'b0;
    // Move request dropped so the hold stays visible
    ctl(32'h0);
    ctl(32'h1);
    check("clear", {s1, hold, en}, {st1(0), 2'b11});
    for (i = 0; i < 7; i++) begin
      mov <= 1'($random(seed));
      raise({grp[i], 4'($unsigned($random(seed)) % 10)});
      cyc(6);
      check("held", s1, st1(1));
      check("off", {en, ctr, sup}, 3'b011);
      hh <= 1'b1;
      cyc(4);
      hh <= 1'b0;
      cyc(2);
      check("hh", {s1, en}, {st1(0), 1'b0});
    end
    ctl(32'h2);
    raise(8'h41);
    check("brake", brk, 1'b1);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    check("cycle", {s1, s3}, {st1(0), 8'h00});
    complete_run();
  end
  initial begin
    cyc(20000);
    bad_count++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
